/* File: include/cod_defines.vh */
// Notes on behaviour
// [RULE1] 1011 bbba ffffffff tests bit, skips next word when clear; 1, 2 or 3 cycles
// [RULE2] 1010 bbba ffffffff tests bit, skips next word when set; same cycle counts
// [RULE3] 1110 0ccc nnnnnnnn branches on one of eight flag conditions; flags untouched
// [RULE4] branch takes one cycle when false, two with counter load when true
// [RULE5] call is 1110 110s plus 1111 word, two cycles, s asks shadow save
// [RULE6] jump is 1110 1111 plus 1111 word, two cycles, flags untouched
// [RULE7] 0x0006 drops stack top, 0x0005 pushes next address, one cycle each
// [RULE8] 0000 0000 0001 000s returns from interrupt, sets both enables, s restores shadow
// [RULE9] 0000 1100 kkkkkkkk loads literal to working register and returns, two cycles
// [RULE10] 0x0003 enters standby in one cycle and updates timeout and power-down flags
// [RULE11] counter-changing or true-test instructions take two cycles, second is no-operation; call and jump load the counter in their second cycle instead
// [RULE12] a lone 1111 word executes as no-operation
// [RULE13] skipped word is suppressed; a skipped two-word form costs one more cycle
`ifndef COD_DEFINES_VH
`define COD_DEFINES_VH

// opcode patterns
`define COD_NIB_SKIP_CLR 4'hb
`define COD_NIB_SKIP_SET 4'ha
`define COD_NIB_WORD2 4'hf
`define COD_TOP5_BRANCH 5'h1c
`define COD_TOP7_CALL 7'h76
`define COD_BYTE_JUMP 8'hef
`define COD_BYTE_LITRET 8'h0c
`define COD_TOP15_IRET 15'h0008
`define COD_WORD_POP 16'h0006
`define COD_WORD_PUSH 16'h0005
`define COD_WORD_STANDBY 16'h0003

// operation classes reported on op_class_o
`define COD_OP_NOP 4'h0
`define COD_OP_SKIP_CLR 4'h1
`define COD_OP_SKIP_SET 4'h2
`define COD_OP_BRANCH 4'h3
`define COD_OP_CALL 4'h4
`define COD_OP_JUMP 4'h5
`define COD_OP_POP 4'h6
`define COD_OP_PUSH 4'h7
`define COD_OP_IRET 4'h8
`define COD_OP_LITRET 4'h9
`define COD_OP_STANDBY 4'ha
`define COD_OP_OTHER 4'hb

// cycle figures
`define COD_CYC_ONE 2'h1
`define COD_CYC_TWO 2'h2
`define COD_CYC_THREE 2'h3

// register byte offsets
`define COD_REG_CTRL 4'h0
`define COD_REG_STATUS 4'h4
`define COD_REG_COUNT 4'h8

// field positions
`define COD_CTRL_EN_BIT 0
`define COD_STAT_BAD2_BIT 7
`define COD_CTRL_RESET 1'b1

`endif

/* File: design/cod_cond_eval.v */
`timescale 1ns/1ps
// branch condition: upper two bits pick the flag, low bit inverts
module cod_cond_eval (
    input wire [2:0] cond_i,
    input wire flag_z_i,
    input wire flag_c_i,
    input wire flag_ov_i,
    input wire flag_n_i,
    output reg taken_o
);
    reg sel;

    // even codes test the flag set, odd codes test it clear
    always @* begin
        sel = 1'b0;
        case (cond_i[2:1])
            2'h0: sel = flag_z_i;
            2'h1: sel = flag_c_i;
            2'h2: sel = flag_ov_i;
            2'h3: sel = flag_n_i;
            default: sel = 1'b0;
        endcase
        taken_o = sel ^ cond_i[0]; // RULE3
    end
endmodule

/* File: design/cod_decoder.v */
// Decided for this implementation: the placing of the registers and register access over Avalon-MM.
`timescale 1ns/1ps
`include "cod_defines.vh"
module cod_decoder (
    input wire sys_clk_i,
    input wire sys_rst_i,
    input wire instr_valid_i,
    input wire [15:0] instr_word_i,
    output wire instr_ready_o,
    input wire bit_value_i,
    input wire flag_z_i,
    input wire flag_c_i,
    input wire flag_ov_i,
    input wire flag_n_i,
    output reg op_valid_o,
    output reg [3:0] op_class_o,
    output reg suppress_o,
    output reg [2:0] bit_index_o,
    output reg access_sel_o,
    output reg [7:0] reg_addr_o,
    output reg pc_rel_load_o,
    output reg [7:0] pc_offset_o,
    output reg pc_abs_load_o,
    output reg [19:0] pc_target_o,
    output reg pc_stack_load_o,
    output reg stack_push_o,
    output reg stack_pop_o,
    output reg shadow_save_o,
    output reg shadow_restore_o,
    output reg global_high_irq_enable_set_o,
    output reg peripheral_low_irq_enable_set_o,
    output reg working_register_load_o,
    output reg [7:0] working_register_data_o,
    output reg standby_o,
    output reg power_flags_upd_o,
    input wire [3:0] avs_address_i,
    input wire avs_read_i,
    input wire avs_write_i,
    input wire [31:0] avs_writedata_i,
    input wire [3:0] avs_byteenable_i,
    output reg [31:0] avs_readdata_o,
    output reg avs_waitrequest_o
);
    localparam [2:0] S_DEC = 3'h0;
    localparam [2:0] S_WORD2 = 3'h1;
    localparam [2:0] S_FLUSH = 3'h2;
    localparam [2:0] S_SKIP1 = 3'h3;
    localparam [2:0] S_SKIP2 = 3'h4;

    reg [2:0] state_q, state_d;
    reg ready_q, en_q, bad2_q, bad2_set, done;
    reg call_q, call_d, save_q, save_d;
    reg [7:0] low_q, low_d;
    reg [3:0] last_op_q, last_op_d;
    reg [1:0] last_cyc_q, last_cyc_d;
    reg [15:0] count_q;
    reg op_valid_d, suppress_d, pc_rel_d, pc_abs_d, pc_stack_d;
    reg push_d, pop_d, save_out_d, restore_d, irq_set_d, working_register_ld_d, standby_d, pflags_d;
    reg [3:0] op_class_d;
    reg [19:0] target_d;
    wire take, taken, is_two_first, bus_req, bus_acc;
    wire [15:0] w;

    assign instr_ready_o = ready_q;
    assign take = instr_valid_i & ready_q;
    assign w = instr_word_i;
    assign is_two_first = (w[15:9] == `COD_TOP7_CALL) | (w[15:8] == `COD_BYTE_JUMP);
    assign bus_req = avs_read_i | avs_write_i;
    assign bus_acc = bus_req & ~avs_waitrequest_o;

    cod_cond_eval u_cond (
        .cond_i(w[10:8]),
        .flag_z_i(flag_z_i),
        .flag_c_i(flag_c_i),
        .flag_ov_i(flag_ov_i),
        .flag_n_i(flag_n_i),
        .taken_o(taken)
    );

    // next-state and one-cycle command pulses
    always @* begin
        state_d = state_q;
        call_d = call_q;
        save_d = save_q;
        low_d = low_q;
        last_op_d = last_op_q;
        last_cyc_d = last_cyc_q;
        bad2_set = 1'b0;
        done = 1'b0;
        op_valid_d = 1'b0;
        op_class_d = `COD_OP_NOP;
        suppress_d = 1'b0;
        pc_rel_d = 1'b0;
        pc_abs_d = 1'b0;
        pc_stack_d = 1'b0;
        push_d = 1'b0;
        pop_d = 1'b0;
        save_out_d = 1'b0;
        restore_d = 1'b0;
        irq_set_d = 1'b0;
        working_register_ld_d = 1'b0;
        standby_d = 1'b0;
        pflags_d = 1'b0;
        target_d = pc_target_o;
        case (state_q)
            S_DEC: begin
                if (take) begin
                    op_valid_d = 1'b1;
                    done = 1'b1;
                    last_cyc_d = `COD_CYC_ONE;
                    // disabled decoder turns every word into a no-operation
                    if (!en_q) begin
                        op_class_d = `COD_OP_NOP;
                    end else if (w[15:12] == `COD_NIB_SKIP_CLR) begin
                        op_class_d = `COD_OP_SKIP_CLR;
                        if (!bit_value_i) begin
                            state_d = S_SKIP1; // RULE1
                            done = 1'b0;
                        end
                    end else if (w[15:12] == `COD_NIB_SKIP_SET) begin
                        op_class_d = `COD_OP_SKIP_SET;
                        if (bit_value_i) begin
                            state_d = S_SKIP1; // RULE2
                            done = 1'b0;
                        end
                    end else if (w[15:11] == `COD_TOP5_BRANCH) begin
                        op_class_d = `COD_OP_BRANCH;
                        // false condition finishes here in one cycle
                        if (taken) begin
                            pc_rel_d = 1'b1; // RULE4
                            state_d = S_FLUSH; // RULE11
                            done = 1'b0;
                        end
                    end else if (w[15:8] == `COD_BYTE_JUMP) begin
                        op_class_d = `COD_OP_JUMP;
                        low_d = w[7:0]; // RULE6
                        call_d = 1'b0;
                        save_d = 1'b0;
                        state_d = S_WORD2;
                        done = 1'b0;
                    end else if (w[15:9] == `COD_TOP7_CALL) begin
                        op_class_d = `COD_OP_CALL;
                        low_d = w[7:0]; // RULE5
                        call_d = 1'b1;
                        save_d = w[8];
                        state_d = S_WORD2;
                        done = 1'b0;
                    end else if (w == `COD_WORD_POP) begin
                        op_class_d = `COD_OP_POP;
                        pop_d = 1'b1; // RULE7
                    end else if (w == `COD_WORD_PUSH) begin
                        op_class_d = `COD_OP_PUSH;
                        push_d = 1'b1; // RULE7
                    end else if (w[15:1] == `COD_TOP15_IRET) begin
                        op_class_d = `COD_OP_IRET;
                        pc_stack_d = 1'b1; // RULE8
                        pop_d = 1'b1;
                        irq_set_d = 1'b1;
                        restore_d = w[0];
                        state_d = S_FLUSH; // RULE11
                        done = 1'b0;
                    end else if (w[15:8] == `COD_BYTE_LITRET) begin
                        op_class_d = `COD_OP_LITRET;
                        working_register_ld_d = 1'b1; // RULE9
                        pc_stack_d = 1'b1;
                        pop_d = 1'b1;
                        state_d = S_FLUSH; // RULE11
                        done = 1'b0;
                    end else if (w == `COD_WORD_STANDBY) begin
                        op_class_d = `COD_OP_STANDBY;
                        standby_d = 1'b1; // RULE10
                        pflags_d = 1'b1;
                    end else if (w[15:12] == `COD_NIB_WORD2) begin
                        op_class_d = `COD_OP_NOP; // RULE12
                    end else begin
                        op_class_d = `COD_OP_OTHER;
                    end
                    last_op_d = op_class_d;
                end
            end
            S_WORD2: begin
                // second cycle of call or jump consumes the high target word
                if (take) begin
                    op_valid_d = 1'b1;
                    op_class_d = call_q ? `COD_OP_CALL : `COD_OP_JUMP;
                    done = 1'b1;
                    last_cyc_d = `COD_CYC_TWO;
                    state_d = S_DEC;
                    if (w[15:12] == `COD_NIB_WORD2) begin
                        target_d = {w[11:0], low_q}; // RULE5 RULE6
                        pc_abs_d = 1'b1;
                        push_d = call_q;
                        save_out_d = call_q & save_q;
                    end else begin
                        // malformed pair: drop the transfer, flag it to software
                        bad2_set = 1'b1;
                    end
                end
            end
            S_FLUSH: begin
                // dead cycle while the fetch path refills from the new address
                op_valid_d = 1'b1;
                op_class_d = `COD_OP_NOP; // RULE11
                done = 1'b1;
                last_cyc_d = `COD_CYC_TWO;
                state_d = S_DEC;
            end
            S_SKIP1: begin
                if (take) begin
                    op_valid_d = 1'b1;
                    op_class_d = `COD_OP_NOP;
                    suppress_d = 1'b1; // RULE13
                    if (is_two_first & en_q) begin
                        state_d = S_SKIP2; // RULE13
                    end else begin
                        state_d = S_DEC;
                        done = 1'b1;
                        last_cyc_d = `COD_CYC_TWO; // RULE1 RULE2
                    end
                end
            end
            S_SKIP2: begin
                if (take) begin
                    op_valid_d = 1'b1;
                    op_class_d = `COD_OP_NOP;
                    suppress_d = 1'b1; // RULE13
                    state_d = S_DEC;
                    done = 1'b1;
                    last_cyc_d = `COD_CYC_THREE; // RULE1 RULE2
                end
            end
            default: state_d = S_DEC;
        endcase
    end

    // decoder state and registered command outputs
    always @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            state_q <= S_DEC;
            ready_q <= 1'b1;
            call_q <= 1'b0;
            save_q <= 1'b0;
            low_q <= 8'h00;
            last_op_q <= `COD_OP_NOP;
            last_cyc_q <= 2'h0;
            count_q <= 16'h0000;
            op_valid_o <= 1'b0;
            op_class_o <= `COD_OP_NOP;
            suppress_o <= 1'b0;
            bit_index_o <= 3'h0;
            access_sel_o <= 1'b0;
            reg_addr_o <= 8'h00;
            pc_rel_load_o <= 1'b0;
            pc_offset_o <= 8'h00;
            pc_abs_load_o <= 1'b0;
            pc_target_o <= 20'h00000;
            pc_stack_load_o <= 1'b0;
            stack_push_o <= 1'b0;
            stack_pop_o <= 1'b0;
            shadow_save_o <= 1'b0;
            shadow_restore_o <= 1'b0;
            global_high_irq_enable_set_o <= 1'b0;
            peripheral_low_irq_enable_set_o <= 1'b0;
            working_register_load_o <= 1'b0;
            working_register_data_o <= 8'h00;
            standby_o <= 1'b0;
            power_flags_upd_o <= 1'b0;
        end else begin
            state_q <= state_d;
            ready_q <= (state_d != S_FLUSH);
            call_q <= call_d;
            save_q <= save_d;
            low_q <= low_d;
            last_op_q <= last_op_d;
            last_cyc_q <= last_cyc_d;
            if (done) begin
                count_q <= count_q + 16'h0001;
            end
            op_valid_o <= op_valid_d;
            op_class_o <= op_class_d;
            suppress_o <= suppress_d;
            pc_rel_load_o <= pc_rel_d;
            pc_abs_load_o <= pc_abs_d;
            pc_target_o <= target_d;
            pc_stack_load_o <= pc_stack_d;
            stack_push_o <= push_d;
            stack_pop_o <= pop_d;
            shadow_save_o <= save_out_d;
            shadow_restore_o <= restore_d;
            global_high_irq_enable_set_o <= irq_set_d;
            peripheral_low_irq_enable_set_o <= irq_set_d;
            working_register_load_o <= working_register_ld_d;
            standby_o <= standby_d;
            power_flags_upd_o <= pflags_d;
            // operand fields follow every accepted word in the decode state
            if (take && state_q == S_DEC) begin
                bit_index_o <= w[11:9];
                access_sel_o <= w[8];
                reg_addr_o <= w[7:0];
                pc_offset_o <= w[7:0];
                working_register_data_o <= w[7:0];
            end
        end
    end

    // avalon slave: one wait cycle, then the access is taken
    always @(posedge sys_clk_i or posedge sys_rst_i) begin
        if (sys_rst_i) begin
            avs_waitrequest_o <= 1'b1;
            avs_readdata_o <= 32'h00000000;
            en_q <= `COD_CTRL_RESET;
            bad2_q <= 1'b0;
        end else begin
            avs_waitrequest_o <= ~(bus_req & avs_waitrequest_o);
            if (avs_read_i && avs_waitrequest_o) begin
                case (avs_address_i)
                    `COD_REG_CTRL: avs_readdata_o <= {31'h00000000, en_q};
                    `COD_REG_STATUS: avs_readdata_o <= {24'h000000, bad2_q,
                        (state_q == S_SKIP1) | (state_q == S_SKIP2), last_cyc_q, last_op_q};
                    `COD_REG_COUNT: avs_readdata_o <= {16'h0000, count_q};
                    default: avs_readdata_o <= 32'h00000000;
                endcase
            end
            if (bus_acc && avs_write_i && avs_byteenable_i[0]
                && avs_address_i == `COD_REG_CTRL) begin
                en_q <= avs_writedata_i[`COD_CTRL_EN_BIT];
            end
            // a new malformed pair wins over a clear in the same cycle
            if (bad2_set) begin
                bad2_q <= 1'b1;
            end else if (bus_acc && avs_write_i && avs_byteenable_i[0]
                && avs_address_i == `COD_REG_STATUS
                && avs_writedata_i[`COD_STAT_BAD2_BIT]) begin
                bad2_q <= 1'b0;
            end
        end
    end
endmodule

/* File: verif/cod_decoder_asserts.sv */
`timescale 1ns/1ps
// decoder outputs only, core clock
module cod_decoder_asserts (
    input wire sys_clk_i,
    input wire sys_rst_i,
    input wire instr_ready_o,
    input wire op_valid_o,
    input wire [3:0] op_class_o,
    input wire suppress_o,
    input wire pc_rel_load_o,
    input wire pc_abs_load_o,
    input wire pc_stack_load_o,
    input wire stack_push_o,
    input wire stack_pop_o,
    input wire shadow_save_o,
    input wire global_high_irq_enable_set_o,
    input wire working_register_load_o,
    input wire standby_o,
    input wire power_flags_upd_o
);
    default clocking cb @(posedge sys_clk_i);
    endclocking
    default disable iff (sys_rst_i);

    // flush cycle after a taken branch or return
    sequence flush_s;
        instr_ready_o && op_valid_o && op_class_o == 4'h0;
    endsequence
    sequence ret_s;
        op_valid_o && (op_class_o == 4'h8 || op_class_o == 4'h9);
    endsequence

    branch_flush_a: assert property (pc_rel_load_o |->
        (op_valid_o && op_class_o == 4'h3 && !instr_ready_o) ##1 flush_s)
        else $error("taken branch not followed by one flush cycle");
    return_flush_a: assert property (ret_s |->
        (pc_stack_load_o && stack_pop_o && !instr_ready_o) ##1 flush_s)
        else $error("return not two cycles");
    ready_once_a: assert property (!instr_ready_o |=> instr_ready_o)
        else $error("ready low longer than one cycle");
    irq_enable_a: assert property (op_valid_o && op_class_o == 4'h8 |->
        global_high_irq_enable_set_o)
        else $error("interrupt return without enable set");
    literal_load_a: assert property (
        working_register_load_o == (op_valid_o && op_class_o == 4'h9))
        else $error("literal load not tied to literal return");
    standby_flags_a: assert property (standby_o |->
        power_flags_upd_o && op_valid_o && op_class_o == 4'ha)
        else $error("standby without power flag update");
    far_load_a: assert property (pc_abs_load_o |->
        op_valid_o && (op_class_o == 4'h4 || op_class_o == 4'h5) && instr_ready_o)
        else $error("absolute load outside call or jump");
    call_save_a: assert property (shadow_save_o |->
        pc_abs_load_o && stack_push_o && op_class_o == 4'h4)
        else $error("shadow save outside call second word");
    stack_word_a: assert property (op_valid_o && op_class_o == 4'h6 |->
        stack_pop_o && !stack_push_o && instr_ready_o)
        else $error("stack drop wrong");
    suppress_nop_a: assert property (suppress_o |->
        op_valid_o && op_class_o == 4'h0 && !pc_rel_load_o && !pc_abs_load_o)
        else $error("skipped word had an effect");
endmodule

bind cod_decoder cod_decoder_asserts i_cod_decoder_asserts (.*);

/* File: verif/cod_fetch_model.sv */
`timescale 1ns/1ps
// fetch side: offers a word with its flags and holds it until taken
module cod_fetch_model (
    input wire sys_clk_i,
    input wire instr_ready_i,
    output logic instr_valid_o,
    output logic [15:0] instr_word_o,
    output logic bit_value_o,
    output logic [3:0] flags_o
);
    initial begin
        instr_valid_o = 1'b0;
        instr_word_o = 16'h0;
        bit_value_o = 1'b0;
        flags_o = 4'h0;
    end

    // released word bus toggles so a stale word never looks valid
    task automatic idle(input int n);
        repeat (n) begin
            instr_valid_o <= 1'b0;
            instr_word_o <= ~instr_word_o;
            @(posedge sys_clk_i);
        end
    endtask

    // returns at the taking edge; next send is back to back
    task automatic send(input logic [15:0] w, input logic b, input logic [3:0] f, input int gap);
        int n;
        n = 0;
        idle(gap);
        instr_valid_o <= 1'b1;
        instr_word_o <= w;
        bit_value_o <= b;
        flags_o <= f;
        do @(posedge sys_clk_i); while (instr_ready_i !== 1'b1 && ++n < 20);
    endtask
endmodule

/* File: verif/cod_decoder_test.sv */
`timescale 1ns/1ps
module cod_decoder_test;
    logic sys_clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic [3:0] avs_address_i = 4'h0;
    logic avs_read_i = 1'b0;
    logic avs_write_i = 1'b0;
    logic [31:0] avs_writedata_i = 32'h0;
    logic [3:0] avs_byteenable_i = 4'hf;
    wire instr_valid_i, bit_value_i, flag_z_i, flag_c_i, flag_ov_i, flag_n_i, instr_ready_o;
    wire op_valid_o, suppress_o, access_sel_o, pc_rel_load_o, pc_abs_load_o;
    wire stack_push_o, stack_pop_o, standby_o, avs_waitrequest_o;
    wire [15:0] instr_word_i;
    wire [3:0] op_class_o;
    wire [2:0] bit_index_o;
    wire [7:0] reg_addr_o, pc_offset_o, working_register_data_o;
    wire [19:0] pc_target_o;
    wire [31:0] avs_readdata_o;
    wire pc_stack_load_o, shadow_save_o, shadow_restore_o, global_high_irq_enable_set_o;
    wire peripheral_low_irq_enable_set_o, working_register_load_o, power_flags_upd_o;
    wire [16:0] obs_w = {power_flags_upd_o, working_register_load_o,
        peripheral_low_irq_enable_set_o, global_high_irq_enable_set_o, shadow_restore_o,
        shadow_save_o, pc_stack_load_o, standby_o, stack_pop_o, stack_push_o, pc_abs_load_o,
        pc_rel_load_o, suppress_o, op_class_o};
    int error_cnt = 0;
    int samples_checked = 0;
    int last_cyc = 0;
    logic [16:0] exp_q[$];
    logic [16:0] e;
    logic [7:0] rnd = 8'h24;
    logic [31:0] rd;
    logic [15:0] last_w;
    logic skip_m = 1'b0;
    logic s_m = 1'b0;
    logic en_m = 1'b1;
    logic [3:0] sec_m = 4'h0;

    cod_decoder i_cod_decoder (.*);
    cod_fetch_model i_cod_fetch_model (.sys_clk_i, .instr_ready_i(instr_ready_o),
        .instr_valid_o(instr_valid_i), .instr_word_o(instr_word_i), .bit_value_o(bit_value_i),
        .flags_o({flag_n_i, flag_ov_i, flag_c_i, flag_z_i}));

    always #20 sys_clk_i = ~sys_clk_i;

    function automatic logic [7:0] lfsr_next(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction

    task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
        samples_checked++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %s expected %h seen %h", nm, exp, got);
        end
    endtask

    task automatic give_verdict;
        $display("comparisons %0d mismatches %0d", samples_checked, error_cnt);
        if (error_cnt == 0 && samples_checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // bus master: request held until waitrequest is sampled low
    task automatic avs(input logic wr, input logic [3:0] a, input logic [31:0] d,
        input logic [3:0] be);
        int n;
        n = 0;
        @(posedge sys_clk_i);
        avs_read_i <= !wr;
        avs_write_i <= wr;
        avs_address_i <= a;
        avs_writedata_i <= d;
        avs_byteenable_i <= be;
        do @(posedge sys_clk_i); while (avs_waitrequest_o !== 1'b0 && ++n < 50);
        check("bus wait", 32'h0, avs_waitrequest_o);
        rd = avs_readdata_o;
        avs_read_i <= 1'b0;
        avs_write_i <= 1'b0;
    endtask

    // reference; bits: pflags wload irqlo irqhi restore save stkload standby pop push abs rel
    // suppress class
    task automatic model(input logic [15:0] w, input logic b, input logic [3:0] f);
        logic t;
        t = f[w[10:9]] ^ w[8];
        if (!en_m) begin
            exp_q.push_back(10'h000);
        end else if (skip_m) begin
            exp_q.push_back(10'h010);
            skip_m = (w[15:9] == 7'h76 || w[15:8] == 8'hef);
        end else if (sec_m != 4'h0) begin
            exp_q.push_back({5'b0, s_m && sec_m == 4'h4 && w[15:12] == 4'hf, 3'b0,
                sec_m == 4'h4 && w[15:12] == 4'hf, w[15:12] == 4'hf, 2'b0, sec_m});
            sec_m = 4'h0;
        end else begin
            casez (w)
                16'hb???: begin exp_q.push_back(10'h001); skip_m = !b; end
                16'ha???: begin exp_q.push_back(10'h002); skip_m = b; end
                16'b1110_0???_????_????: begin
                    exp_q.push_back({4'h0, t, 1'b0, 4'h3});
                    if (t) exp_q.push_back(10'h000);
                    last_cyc = t ? 2 : 1;
                end
                16'b1110_110?_????_????: begin
                    exp_q.push_back(10'h004);
                    sec_m = 4'h4;
                    s_m = w[8];
                end
                16'hef??: begin exp_q.push_back(10'h005); sec_m = 4'h5; end
                16'h0006: exp_q.push_back(10'h106);
                16'h0005: exp_q.push_back(10'h087);
                16'b0000_0000_0001_000?: begin
                    exp_q.push_back({4'h3, w[0], 12'h508});
                    exp_q.push_back(10'h0);
                end
                16'h0c??: begin exp_q.push_back(17'h08509); exp_q.push_back(10'h0); end
                16'h0003: exp_q.push_back(17'h1020a);
                16'hf???: exp_q.push_back(10'h000);
                default: exp_q.push_back(10'h00b);
            endcase
        end
    endtask

    task automatic issue(input logic [15:0] w, input logic b, input logic [3:0] f);
        model(w, b, f);
        last_w = w;
        rnd = lfsr_next(rnd);
        i_cod_fetch_model.send(w, b, f, rnd[1:0] == 2'b00 ? 1 : 0);
    endtask

    // every decoder result against the reference, in order
    always @(negedge sys_clk_i) begin
        if (op_valid_o === 1'b1) begin
            e = (exp_q.size() > 0) ? exp_q.pop_front() : 10'h3ff;
            check("op", e, obs_w);
        end
    end

    initial begin
        repeat (8) @(posedge sys_clk_i);
        sys_rst_i <= 1'b0;
        // reset values, then an unmapped place
        check("ready", 32'h1, instr_ready_o);
        avs(1'b0, 4'h0, 32'h0, 4'hf);
        check("ctrl", 32'h1, rd);
        avs(1'b0, 4'h4, 32'h0, 4'hf);
        check("status", 32'h0, rd);
        avs(1'b0, 4'hc, 32'h0, 4'hf);
        check("unmapped", 32'h0, rd);
        $display("reset test done");
        // all eight conditions, random flags and offsets
        for (int i = 0; i < 16; i++) begin
            rnd = lfsr_next(rnd);
            issue({5'h1c, i[2:0], rnd}, 1'b0, rnd[3:0] ^ rnd[7:4]);
        end
        i_cod_fetch_model.idle(3);
        check("offset", last_w[7:0], pc_offset_o);
        avs(1'b0, 4'h4, 32'h0, 4'hf);
        check("cycles", last_cyc, rd[5:4]);
        avs(1'b0, 4'h8, 32'h0, 4'hf);
        check("count", 32'h10, rd);
        $display("branch test done");
        // call with save, jump, lone second word, bad pair
        issue(16'hed12, 1'b0, 4'h0);
        issue(16'hf345, 1'b0, 4'h0);
        issue(16'hef9a, 1'b0, 4'h0);
        issue(16'hfbcd, 1'b0, 4'h0);
        issue(16'hf00f, 1'b0, 4'h0);
        i_cod_fetch_model.idle(3);
        check("target", 32'hbcd9a, pc_target_o);
        issue(16'hec00, 1'b0, 4'h0);
        issue(16'h1234, 1'b0, 4'h0);
        i_cod_fetch_model.idle(1);
        // sticky flag: ignored without the low byte lane, then cleared
        avs(1'b1, 4'h4, 32'h80, 4'he);
        avs(1'b0, 4'h4, 32'h0, 4'hf);
        check("bad word", 32'h1, rd[7]);
        avs(1'b1, 4'h4, 32'h80, 4'hf);
        avs(1'b0, 4'h4, 32'h0, 4'hf);
        check("bad clear", 32'h0, rd[7]);
        $display("two-word test done");
        // stack words, returns, standby and an undecoded word
        issue(16'h0006, 1'b0, 4'h0);
        issue(16'h0005, 1'b0, 4'h0);
        issue(16'h0011, 1'b0, 4'h0);
        issue(16'h5012, 1'b0, 4'h0);
        issue(16'h0003, 1'b0, 4'h0);
        issue({8'h0c, rnd}, 1'b0, 4'h0);
        i_cod_fetch_model.idle(3);
        check("literal", last_w[7:0], working_register_data_o);
        $display("control test done");
        // skip a call, skip a branch, skip not taken
        issue(16'hb6a5, 1'b0, 4'h0);
        issue(16'hec11, 1'b0, 4'h0);
        issue(16'hf222, 1'b0, 4'h0);
        issue(16'ha2ff, 1'b1, 4'h0);
        issue(16'he0ff, 1'b0, 4'h1);
        issue(16'hb3c7, 1'b1, 4'h0);
        i_cod_fetch_model.idle(3);
        check("fields", 32'h3c7, {bit_index_o, access_sel_o, reg_addr_o});
        $display("skip test done");
        // decode off: branch and return do nothing
        avs(1'b1, 4'h0, 32'h0, 4'hf);
        en_m = 1'b0;
        issue(16'he000, 1'b0, 4'h1);
        issue(16'h0010, 1'b0, 4'h0);
        i_cod_fetch_model.idle(2);
        avs(1'b1, 4'h0, 32'h1, 4'hf);
        en_m = 1'b1;
        issue(16'h0003, 1'b0, 4'h0);
        i_cod_fetch_model.idle(4);
        check("left over", 32'h0, exp_q.size());
        $display("enable test done");
        give_verdict();
    end

    // watchdog, well past test length
    initial begin
        repeat (5000) @(posedge sys_clk_i);
        error_cnt++;
        give_verdict();
    end
endmodule
